// ===== pkg/acs_pkg.sv
/*
   Package for the converter sequencer: register offsets, field positions, reset values,
   timing counts and the carrier structs. Assumes a 32-bit Avalon-MM register bus.
*/
// What this block does
// R1: Channel and reference apply only while enabled.
// R2: Ten-bit result in two bytes, alignable.
// R3: Low byte read locks both result bytes.
// R4: High byte read unlocks result updates.
// R5: Software reads low byte then high byte.
// R6: Complete flag sets even when result dropped.
// R7: Start bit begins conversion, clears at end.
// R8: Channel change waits for running conversion.
// R9: Trigger rising edge resets prescaler, starts.
// R10: Trigger edges during conversion are ignored.
// R11: Held trigger level never restarts conversion.
// R12: Software clears flag trigger before next event.
// R13: Complete flag as trigger means free running.
// R14: Start bit works and reads busy always.
// R15: Prescaler runs while enabled, reset otherwise.
// R16: Software start waits for next converter clock.
// R17: Thirteen cycles normal, twenty-five first conversion.
// R18: Sample at 1.5 normal, 14.5 first.
// R19: Completion stores result, sets flag, clears start.
// R20: Triggered sample two cycles after edge.
// R21: Free running restarts at once, start stays.
// R22: Software keeps converter clock 50 to 200 kHz.
// R23: Selection tracked until start, locked during.
// R24: Input disable bit forces pin bit zero.
package acs_pkg;
   localparam logic [3:0] OFS_CHREF   = 4'h0;
   localparam logic [3:0] OFS_CTRL_A  = 4'h4;
   localparam logic [3:0] OFS_CTRL_B  = 4'h8;
   localparam logic [3:0] OFS_RES_LO  = 4'hC;
   localparam logic [3:0] OFS_RES_HI  = 4'h0;
   localparam logic [5:0] OFS_HI_FULL = 6'h10;
   localparam logic [5:0] OFS_DIDR    = 6'h14;
   localparam logic [5:0] OFS_PINS    = 6'h18;
   // Channel/reference register fields.
   localparam int CH_LSB  = 0;
   localparam int LAR_BIT = 5;
   localparam int REF_BIT = 6;
   // Control A fields, then the control B trigger select, reset byte and input disable mask.
   localparam int PS_LSB   = 0;
   localparam int IE_BIT   = 3;
   localparam int IF_BIT   = 4;
   localparam int ATE_BIT  = 5;
   localparam int SC_BIT   = 6;
   localparam int EN_BIT   = 7;
   localparam int TS_LSB   = 0;
   localparam logic [2:0] TS_FREE = 3'h0;
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [7:0] DIDR_MASK = 8'h3F;
   // Timing in converter clock cycles, counted in half cycles.
   localparam logic [5:0] HALF_NORMAL = 6'd26;
   localparam logic [5:0] HALF_FIRST  = 6'd50;
   localparam logic [5:0] SH_NORMAL   = 6'd3;
   localparam logic [5:0] SH_FIRST    = 6'd29;
   localparam logic [5:0] SH_AUTO     = 6'd4;
   localparam logic [5:0] HALF_AUTO   = 6'd27;
   typedef struct packed {
      logic       ref_sel;
      logic [1:0] chan;
   } acs_sel_s;
   typedef struct packed {
      logic       sample;
      logic       busy;
      acs_sel_s   sel;
   } acs_ana_s;
endpackage

// ===== src/acs_sequencer.sv
/*
   Converter sequencer top: Avalon-MM register slave, prescaler, start/trigger logic,
   conversion timing, result lock. Assumes the SAR array returns its 10-bit code on
   SAR_RESULT by the end of a conversion and that triggers arrive asynchronously.
*/
// Decided for this implementation: the Avalon-MM slave port and the address map.
`timescale 1ns/1ns
`default_nettype none
module acs_sequencer (
   input  wire logic         CORE_CLK,
   input  wire logic         NRST,
   input  wire logic [5:0]   AVS_ADDRESS,
   input  wire logic         AVS_READ,
   input  wire logic         AVS_WRITE,
   input  wire logic [31:0]  AVS_WRITEDATA,
   input  wire logic [3:0]   AVS_BYTEENABLE,
   output logic      [31:0]  AVS_READDATA,
   output logic              AVS_WAITREQUEST,
   input  wire logic [7:0]   TRIGGER_IN,
   input  wire logic [9:0]   SAR_RESULT,
   input  wire logic [5:0]   PIN_IN,
   output acs_pkg::acs_ana_s ANALOG_CTRL,
   output logic              CONV_DONE_IRQ
);
   logic [7:0] chref, ctrl_b, didr;
   logic       en, sc, ate, ie, flag;
   logic [2:0] ps;
   logic [9:0] res;
   logic       locked, first, busy, auto_run;
   logic [5:0] half;
   logic [7:0] pre;
   logic [1:0] trg_s0, trg_s1, trg_s2;
   logic       trg_prev;
   logic [5:0] pin_s0, pin_s1;
   logic       done, wr, rd, fin;
   logic       trig_sel, trig_rise, ack;
   logic       adc_edge;
   logic       pend;
   logic       first_conv;
   logic [5:0] sh_point;
   acs_pkg::acs_sel_s sel_buf;

   // Bus answers in the cycle after the request; waitrequest drops for that one edge.
   // A write lands at the request edge; ack masks the held request at the answer edge.
   assign wr = AVS_WRITE && !ack;
   assign rd = AVS_READ && !ack;
   always_ff @(posedge CORE_CLK or negedge NRST) begin
      if (!NRST) begin
         ack <= 1'b0;
         AVS_WAITREQUEST <= 1'b1;
      end else begin
         ack <= (AVS_READ || AVS_WRITE) && !ack;
         AVS_WAITREQUEST <= !((AVS_READ || AVS_WRITE) && !ack);
      end
   end

   // Two-flop synchroniser on the selected trigger, then two stages (trg_s1, trg_prev) for the edge detector.
   // Only the second flop fans out, so a metastable first stage never reaches logic.
   // Changing the trigger source while armed may show one false edge.
   always_ff @(posedge CORE_CLK or negedge NRST) begin
      if (!NRST) begin
         trg_s0 <= 2'b00;
         trg_s1 <= 2'b00;
         trg_prev <= 1'b0;
      end else begin
         trg_s0 <= {trg_s0[0], TRIGGER_IN[ctrl_b[2:0]]};
         trg_s1 <= {2{trg_s0[1]}};
         trg_prev <= trg_s1[1];
      end
   end

   // Pin states pass two flops before the readback sees them.
   always_ff @(posedge CORE_CLK or negedge NRST) begin
      if (!NRST) begin
         pin_s0 <= 6'h00;
         pin_s1 <= 6'h00;
      end else begin
         pin_s0 <= PIN_IN;
         pin_s1 <= pin_s0;
      end
   end
   assign trg_s2 = trg_s1;
   assign trig_sel = (ctrl_b[2:0] == acs_pkg::TS_FREE) ? flag : trg_s2[1];
   // Only a fresh rising edge counts; a held level does nothing.  see R11
   assign trig_rise = ate && en && !busy && (ctrl_b[2:0] != acs_pkg::TS_FREE)
                      && trg_s2[1] && !trg_prev;  // see R9 see R10

   // Prescaler divides by 2^ps (minimum 2), cleared while disabled or on trigger.
   // Clearing it on a trigger fixes the delay from trigger edge to sample.
   always_ff @(posedge CORE_CLK or negedge NRST) begin
      if (!NRST) begin
         pre <= 8'h00;
      end else if (!en || trig_rise) begin
         pre <= 8'h00;  // see R15 see R9
      end else begin
         pre <= pre + 8'h01;
      end
   end
   // Edge pulses at each converter half cycle.
   always_comb begin
      logic [7:0] m;
      m = (ps == 3'h0) ? 8'h00 : ((8'h01 << ps) >> 1) - 8'h01;
      adc_edge = en && ((pre & m) == m);  // see R15
   end

   assign done = busy && (half == 6'd1) && adc_edge;
   assign fin = done;

   always_ff @(posedge CORE_CLK or negedge NRST) begin
      if (!NRST) begin
         busy <= 1'b0;
         half <= 6'h00;
         first <= 1'b1;
         auto_run <= 1'b0;
         pend <= 1'b0;
         first_conv <= 1'b0;
      end else if (!en) begin
         busy <= 1'b0;
         half <= 6'h00;
         first <= 1'b1;  // see R17
         pend <= 1'b0;
         first_conv <= 1'b0;
      end else if (trig_rise) begin
         busy <= 1'b1;
         auto_run <= 1'b1;
         half <= first ? acs_pkg::HALF_FIRST : acs_pkg::HALF_AUTO;  // see R20
         first <= 1'b0;
         first_conv <= first;
      end else if (adc_edge) begin
         if (busy) begin
            half <= half - 6'd1;
            if (half == 6'd1) begin
               // Free running restarts immediately.  see R13 see R21
               busy <= ate && (ctrl_b[2:0] == acs_pkg::TS_FREE);
               half <= acs_pkg::HALF_NORMAL;
               auto_run <= 1'b0;
               first_conv <= 1'b0;
            end
         end else if (pend || sc) begin
            busy <= 1'b1;  // see R16
            pend <= 1'b0;
            half <= first ? acs_pkg::HALF_FIRST : acs_pkg::HALF_NORMAL;  // see R17
            first <= 1'b0;
            first_conv <= first;
         end
      end
   end

   // Selection follows the register until start, locked during, tracking near the end.
   always_ff @(posedge CORE_CLK or negedge NRST) begin
      if (!NRST) begin
         sel_buf <= '0;
      end else if (en && (!busy || half <= 6'd2)) begin
         sel_buf <= {chref[acs_pkg::REF_BIT], chref[1:0]};  // see R1 see R8 see R23
      end
   end

   // Sample pulse placed by the half-cycle countdown.
   always_ff @(posedge CORE_CLK or negedge NRST) begin
      if (!NRST) begin
         ANALOG_CTRL <= '0;
      end else begin
         ANALOG_CTRL.sel <= sel_buf;
         ANALOG_CTRL.busy <= busy;
         ANALOG_CTRL.sample <= busy && adc_edge && (half == sh_point);  // see R18 see R20
      end
   end

   // Sample point as a countdown value; the first conversion after enable samples late
   // because the analog side spends its extra cycles settling before it holds.
   always_comb begin
      if (first_conv) begin
         sh_point = acs_pkg::HALF_FIRST - acs_pkg::SH_FIRST;
      end else if (auto_run) begin
         sh_point = acs_pkg::HALF_AUTO - acs_pkg::SH_AUTO;
      end else begin
         sh_point = acs_pkg::HALF_NORMAL - acs_pkg::SH_NORMAL;
      end
   end

   // Registers.
   always_ff @(posedge CORE_CLK or negedge NRST) begin
      if (!NRST) begin
         chref <= acs_pkg::RST_BYTE;
         ctrl_b <= acs_pkg::RST_BYTE;
         didr <= acs_pkg::RST_BYTE;
         en <= 1'b0;
         sc <= 1'b0;
         ate <= 1'b0;
         ie <= 1'b0;
         ps <= 3'h0;
         flag <= 1'b0;
      end else begin
         if (wr && AVS_BYTEENABLE[0]) begin
            if (AVS_ADDRESS == 6'(acs_pkg::OFS_CHREF)) begin
               chref <= AVS_WRITEDATA[7:0];
            end else if (AVS_ADDRESS == 6'(acs_pkg::OFS_CTRL_B)) begin
               // Only the trigger select field exists; the other bits read zero.
               ctrl_b <= AVS_WRITEDATA[7:0] & 8'h07;
            end else if (AVS_ADDRESS == acs_pkg::OFS_DIDR) begin
               didr <= AVS_WRITEDATA[7:0] & acs_pkg::DIDR_MASK;
            end else if (AVS_ADDRESS == 6'(acs_pkg::OFS_CTRL_A)) begin
               en <= AVS_WRITEDATA[acs_pkg::EN_BIT];
               ate <= AVS_WRITEDATA[acs_pkg::ATE_BIT];
               ie <= AVS_WRITEDATA[acs_pkg::IE_BIT];
               ps <= AVS_WRITEDATA[2:0];
            end
         end
         // Start bit: set by software, held while busy, cleared on completion except when free running.  see R7 see R14
         if (wr && AVS_BYTEENABLE[0] && AVS_ADDRESS == 6'(acs_pkg::OFS_CTRL_A)
             && AVS_WRITEDATA[acs_pkg::SC_BIT] && AVS_WRITEDATA[acs_pkg::EN_BIT])
            sc <= 1'b1;
         else if (fin && !(ate && ctrl_b[2:0] == acs_pkg::TS_FREE))
            sc <= 1'b0;  // see R19
         else if (busy)
            sc <= 1'b1;
         else if (!en)
            sc <= 1'b0;
         // Flag set wins over write-one clear.  see R6 see R19
         if (fin)
            flag <= 1'b1;
         else if (wr && AVS_BYTEENABLE[0] && AVS_ADDRESS == 6'(acs_pkg::OFS_CTRL_A)
                  && AVS_WRITEDATA[acs_pkg::IF_BIT])
            flag <= 1'b0;
      end
   end

   // Result store with read lock.
   // A completion that meets the lock is dropped; the flag still sets so software can tell.
   always_ff @(posedge CORE_CLK or negedge NRST) begin
      if (!NRST) begin
         res <= 10'h000;
         locked <= 1'b0;
      end else begin
         if (fin && !locked)
            res <= SAR_RESULT;  // see R3
         if (rd && AVS_ADDRESS == acs_pkg::OFS_HI_FULL)
            locked <= 1'b0;  // see R4
         else if (rd && AVS_ADDRESS == 6'(acs_pkg::OFS_RES_LO))
            locked <= 1'b1;  // see R3
      end
   end

   always_ff @(posedge CORE_CLK or negedge NRST) begin
      if (!NRST) begin
         AVS_READDATA <= 32'h0000_0000;
         CONV_DONE_IRQ <= 1'b0;
      end else begin
         CONV_DONE_IRQ <= flag && ie;
         AVS_READDATA <= 32'h0000_0000;
         if (rd) begin
            if (AVS_ADDRESS == 6'(acs_pkg::OFS_CHREF)) begin
               AVS_READDATA[7:0] <= chref;
            end else if (AVS_ADDRESS == 6'(acs_pkg::OFS_CTRL_A)) begin
               AVS_READDATA[7:0] <= {en, sc, ate, flag, ie, ps};  // see R14
            end else if (AVS_ADDRESS == 6'(acs_pkg::OFS_CTRL_B)) begin
               AVS_READDATA[7:0] <= ctrl_b;
            end else if (AVS_ADDRESS == 6'(acs_pkg::OFS_RES_LO)) begin
               AVS_READDATA[7:0] <= chref[acs_pkg::LAR_BIT] ? {res[1:0], 6'h00}
                                                            : res[7:0];  // see R2
            end else if (AVS_ADDRESS == acs_pkg::OFS_HI_FULL) begin
               AVS_READDATA[7:0] <= chref[acs_pkg::LAR_BIT] ? res[9:2]
                                                            : {6'h00, res[9:8]};  // see R2
            end else if (AVS_ADDRESS == acs_pkg::OFS_DIDR) begin
               AVS_READDATA[7:0] <= didr;
            end else if (AVS_ADDRESS == acs_pkg::OFS_PINS) begin
               // Unmapped addresses read zero because the data word is cleared each cycle.
               AVS_READDATA[5:0] <= pin_s1 & ~didr[5:0];  // see R24
            end
         end
      end
   end

   a_flag_on_done: assert property (@(posedge CORE_CLK) disable iff (!NRST)
      fin |=> flag)  // see R6
      else $error("flag not set after completion");
   a_lock_holds: assert property (@(posedge CORE_CLK) disable iff (!NRST)
      locked && !(rd && AVS_ADDRESS == acs_pkg::OFS_HI_FULL) |=> $stable(res))  // see R3
      else $error("result changed while locked");
   a_sc_busy: assert property (@(posedge CORE_CLK) disable iff (!NRST)
      busy && !fin |=> sc)  // see R14
      else $error("start bit low during conversion");
   a_pre_reset: assert property (@(posedge CORE_CLK) disable iff (!NRST)
      !en |=> pre == 8'h00)  // see R15
      else $error("prescaler runs while disabled");
   a_sc_clear: assert property (@(posedge CORE_CLK) disable iff (!NRST)
      fin && !ate |=> !sc)  // see R19
      else $error("start bit not cleared");
   a_no_retrig: assert property (@(posedge CORE_CLK) disable iff (!NRST)
      busy && !fin |=> !trig_rise)  // see R10
      else $error("trigger accepted while busy");
   a_unlock: assert property (@(posedge CORE_CLK) disable iff (!NRST)
      rd && AVS_ADDRESS == acs_pkg::OFS_HI_FULL |=> !locked)  // see R4
      else $error("high read left lock set");
   a_free_run: assert property (@(posedge CORE_CLK) disable iff (!NRST)
      fin && ate && en && ctrl_b[2:0] == acs_pkg::TS_FREE |=> busy && sc)  // see R21
      else $error("free running did not restart");

   // Bus handshake: one wait state, then a single answer edge.
   a_wait_answer: assert property (@(posedge CORE_CLK) disable iff (!NRST)
      (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
      else $error("no answer one cycle after request");

   a_wait_single: assert property (@(posedge CORE_CLK) disable iff (!NRST)
      !AVS_WAITREQUEST |=> AVS_WAITREQUEST)
      else $error("answer held longer than one cycle");

   // Result lock and store, flag clear and interrupt gate.
   a_lock_on_low: assert property (@(posedge CORE_CLK) disable iff (!NRST)  // see R3
      rd && AVS_ADDRESS == 6'(acs_pkg::OFS_RES_LO) |=> locked)
      else $error("low read did not lock");

   a_result_store: assert property (@(posedge CORE_CLK) disable iff (!NRST)  // see R19
      fin && !locked |=> res == $past(SAR_RESULT))
      else $error("result not stored on completion");

   a_flag_clear: assert property (@(posedge CORE_CLK) disable iff (!NRST)
      wr && AVS_BYTEENABLE[0] && AVS_ADDRESS == 6'(acs_pkg::OFS_CTRL_A)
      && AVS_WRITEDATA[acs_pkg::IF_BIT] && !fin |=> !flag)
      else $error("flag not cleared by write of one");

   a_irq_gate: assert property (@(posedge CORE_CLK) disable iff (!NRST)
      !ie |=> !CONV_DONE_IRQ)
      else $error("interrupt raised while disabled");

   // Selection buffer.
   a_sel_gated: assert property (@(posedge CORE_CLK) disable iff (!NRST)  // see R1
      !en |=> $stable(sel_buf))
      else $error("selection moved while disabled");

   a_sel_locked: assert property (@(posedge CORE_CLK) disable iff (!NRST)  // see R8 see R23
      en && busy && half > 6'd3 |=> $stable(sel_buf))
      else $error("selection moved during conversion");

   // Sequencing.
   a_pre_on_trig: assert property (@(posedge CORE_CLK) disable iff (!NRST)  // see R9
      trig_rise |=> pre == 8'h00)
      else $error("trigger did not clear prescaler");

   a_half_range: assert property (@(posedge CORE_CLK) disable iff (!NRST)  // see R17
      busy |-> half != 6'd0 && half <= acs_pkg::HALF_FIRST)
      else $error("countdown out of range");

   a_sample_busy: assert property (@(posedge CORE_CLK) disable iff (!NRST)  // see R18
      ANALOG_CTRL.sample |-> ANALOG_CTRL.busy)
      else $error("sample outside conversion");

   a_start_edge: assert property (@(posedge CORE_CLK) disable iff (!NRST)  // see R16
      en && !busy && sc && adc_edge && !trig_rise |=> busy)
      else $error("start not taken at converter edge");

   a_held_trigger: assert property (@(posedge CORE_CLK) disable iff (!NRST)  // see R11
      fin && !(ate && ctrl_b[2:0] == acs_pkg::TS_FREE) |=> !busy)
      else $error("conversion restarted without new edge");

   a_auto_len: assert property (@(posedge CORE_CLK) disable iff (!NRST)  // see R20
      trig_rise && !first |=> half == acs_pkg::HALF_AUTO)
      else $error("triggered conversion length wrong");

   a_free_keep: assert property (@(posedge CORE_CLK) disable iff (!NRST)  // see R21
      busy && ate && ctrl_b[2:0] == acs_pkg::TS_FREE |=> sc)
      else $error("start bit dropped while free running");

   a_off_idle: assert property (@(posedge CORE_CLK) disable iff (!NRST)
      !en |=> !busy)
      else $error("conversion running while disabled");

   c_single: cover property (@(posedge CORE_CLK) disable iff (!NRST) fin && !ate);
   c_free: cover property (@(posedge CORE_CLK) disable iff (!NRST)
      fin && ate && ctrl_b[2:0] == acs_pkg::TS_FREE);
   c_first: cover property (@(posedge CORE_CLK) disable iff (!NRST) fin && first_conv);
   c_trig: cover property (@(posedge CORE_CLK) disable iff (!NRST) trig_rise);
   c_lost: cover property (@(posedge CORE_CLK) disable iff (!NRST) fin && locked);
endmodule
`default_nettype wire

// ===== sim/acs_sar_model.sv
/*
   Behavioural successive-approximation array facing the sequencer.
   Assumes the sequencer pulses sample once per conversion with the channel selection valid.
*/
`timescale 1ns/1ns
`default_nettype none
module acs_sar_model (
   input  wire logic              clk,
   input  wire acs_pkg::acs_ana_s ctrl,
   output logic [9:0]             code
);
   logic held;
   initial begin
      held = 1'b0;
      code = 10'h2AA;
   end
   // Before the first sample the code toggles, so a premature capture never looks valid.
   always @(posedge clk) begin
      if (ctrl.sample === 1'b1) begin
         code <= {ctrl.sel.chan, 8'hC3 ^ {6'h00, ctrl.sel.chan}};
         held <= 1'b1;
      end else if (!held) begin
         code <= ~code;
      end
   end
endmodule
`default_nettype wire

// ===== sim/test_adc_conversion_sequencer.sv
/*
   Self-checking bench for the converter sequencer.
   Assumes prescaler setting 0 divides by 2, so one converter cycle is two core cycles.
*/
`timescale 1ns/1ns
`default_nettype none
module test_adc_conversion_sequencer;
   localparam logic [7:0] EN = 8'h01 << acs_pkg::EN_BIT;
   localparam logic [7:0] SC = 8'h01 << acs_pkg::SC_BIT;
   localparam logic [7:0] AT = 8'h01 << acs_pkg::ATE_BIT;
   localparam logic [7:0] IF = 8'h01 << acs_pkg::IF_BIT;
   localparam logic [5:0] A_CH = {2'b00, acs_pkg::OFS_CHREF};
   localparam logic [5:0] A_CA = {2'b00, acs_pkg::OFS_CTRL_A};
   localparam logic [5:0] A_CB = {2'b00, acs_pkg::OFS_CTRL_B};
   localparam logic [5:0] A_LO = {2'b00, acs_pkg::OFS_RES_LO};
   logic              clk, nrst, rd, wr, wait_req, irq;
   logic [5:0]        addr, pins;
   logic [31:0]       wdata, rdata;
   logic [7:0]        trig, q;
   logic [9:0]        sar;
   acs_pkg::acs_ana_s ana;
   int                fail_count, samples_checked, cycles, run, last_len, convs, n0;
   int                smp, per, gap;
   acs_sequencer dut (.CORE_CLK(clk), .NRST(nrst), .AVS_ADDRESS(addr), .AVS_READ(rd),
      .AVS_WRITE(wr), .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(4'h1), .AVS_READDATA(rdata),
      .AVS_WAITREQUEST(wait_req), .TRIGGER_IN(trig), .SAR_RESULT(sar), .PIN_IN(pins),
      .ANALOG_CTRL(ana), .CONV_DONE_IRQ(irq));
   acs_sar_model sar_model (.clk(clk), .ctrl(ana), .code(sar));
   function automatic logic [9:0] cd(input logic [1:0] ch);
      return {ch, 8'hC3 ^ {6'h00, ch}};
   endfunction
   task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task final_report();
      if (fail_count == 0 && samples_checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // The request is held until waitrequest is seen low at a rising edge.
   task bus(input logic w, input logic [5:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= {24'h000000, d};
      wr <= w;
      rd <= !w;
      @(posedge clk);
      while (wait_req !== 1'b0) @(posedge clk);
      q = rdata[7:0];
      wr <= 1'b0;
      rd <= 1'b0;
   endtask
   task wait_done();
      do bus(1'b0, A_CA, 8'h00); while (q[acs_pkg::SC_BIT] !== 1'b0);
      repeat (2) @(posedge clk);
   endtask
   task t_reset();
      bus(1'b0, A_CA, 8'h00); check("ctrl_a", q, 8'h00);
      bus(1'b0, A_CB, 8'h00); check("ctrl_b", q, 8'h00);
      bus(1'b0, acs_pkg::OFS_DIDR, 8'h00); check("didr", q, 8'h00);
      bus(1'b0, 6'h1C, 8'h00); check("unmapped", q, 8'h00);
   endtask
   task t_pins();
      bus(1'b1, acs_pkg::OFS_DIDR, 8'h05);
      repeat (4) @(posedge clk);
      bus(1'b0, acs_pkg::OFS_PINS, 8'h00); check("pins", q, 8'h3A);
   endtask
   task t_single();
      bus(1'b1, A_CH, 8'h01);
      // Fastest prescaler: a short bench accepts the reduced resolution.
      bus(1'b1, A_CA, EN | SC);
      bus(1'b0, A_CA, 8'h00); check("start_busy", q[6], 1'b1);
      wait_done();
      check("first_len", last_len, 16'd50);
      check("flag", q[4], 1'b1);
      bus(1'b0, A_LO, 8'h00); check("lo_right", q, cd(2'd1) & 10'hFF);
      bus(1'b0, acs_pkg::OFS_HI_FULL, 8'h00); check("hi_right", q, cd(2'd1) >> 8);
   endtask
   task t_left_lock();
      bus(1'b1, A_CA, EN | IF);
      bus(1'b1, A_CH, 8'h22);
      bus(1'b1, A_CA, EN | SC);
      bus(1'b1, A_CH, 8'h23);
      wait_done();
      check("normal_len", last_len, 16'd26);
      bus(1'b0, acs_pkg::OFS_HI_FULL, 8'h00); check("hi_left", q, cd(2'd2) >> 2);
      bus(1'b0, A_LO, 8'h00); check("lo_left", q, {cd(2'd2), 6'h00} & 10'hFF);
      bus(1'b1, A_CA, EN | IF | SC);
      wait_done();
      check("flag_lost", q[4], 1'b1);
      bus(1'b0, acs_pkg::OFS_HI_FULL, 8'h00); check("hi_kept", q, cd(2'd2) >> 2);
      bus(1'b1, A_CA, EN | IF | SC);
      wait_done();
      bus(1'b0, A_LO, 8'h00); check("lo_new", q, {cd(2'd3), 6'h00} & 10'hFF);
      bus(1'b0, acs_pkg::OFS_HI_FULL, 8'h00); check("hi_new", q, cd(2'd3) >> 2);
   endtask
   task t_auto();
      bus(1'b1, A_CH, 8'h00);
      bus(1'b1, A_CB, 8'h01);
      bus(1'b1, A_CA, EN | AT | IF);
      n0 = convs;
      trig <= 8'h02;
      while (ana.busy !== 1'b1) @(posedge clk);
      trig <= 8'h00;
      repeat (4) @(posedge clk);
      trig <= 8'h02;
      while (convs == n0) @(posedge clk);
      repeat (200) @(posedge clk);
      check("auto_count", convs - n0, 16'd1);
      bus(1'b0, A_LO, 8'h00); check("auto_lo", q, cd(2'd0) & 10'hFF);
      bus(1'b0, acs_pkg::OFS_HI_FULL, 8'h00);
      trig <= 8'h00;
   endtask
   task t_free();
      bus(1'b1, A_CB, 8'(acs_pkg::TS_FREE));
      n0 = smp;
      bus(1'b1, A_CA, EN | AT | SC);
      while (smp < n0 + 3) @(posedge clk);
      check("free_len", per, 16'd26);
      bus(1'b0, A_CA, 8'h00); check("free_start", q[6], 1'b1);
      bus(1'b1, A_CA, 8'h00);
   endtask
   always @(posedge clk) begin
      cycles++;
      if (cycles == 30000) begin
         fail_count++;
         final_report();
      end
   end
   // Busy run length in core cycles, recorded when a conversion ends.
   always @(posedge clk) begin
      if (ana.busy === 1'b1) run <= run + 1;
      else run <= 0;
      if (ana.busy !== 1'b1 && run != 0) begin
         last_len <= run;
         convs <= convs + 1;
      end
   end
   // Free running keeps busy high, so sample pulses mark the conversion period.
   always @(posedge clk) begin
      if (ana.sample === 1'b1) begin
         per <= gap;
         gap <= 1;
         smp <= smp + 1;
      end else begin
         gap <= gap + 1;
      end
   end
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial begin
      {nrst, rd, wr, addr, wdata, trig} = '0;
      pins = 6'h3F;
      {fail_count, samples_checked, cycles, run, last_len, convs, n0} = '0;
      {smp, per, gap} = '0;
      repeat (10) @(posedge clk);
      nrst <= 1'b1;
      t_reset();
      t_pins();
      t_single();
      t_left_lock();
      t_auto();
      t_free();
      final_report();
   end
endmodule
`default_nettype wire
